/* sim/rsc_pin_model.sv */
// pull-up model of the board reset pin
`timescale 1ns/1ps
module rsc_pin_model
(
    // clock and request
    input wire logic clk,
    input wire logic press,
    // pin level
    output logic pin_n = 1'h1
);
    always @(posedge clk)
        pin_n <= !press;
endmodule : rsc_pin_model

/* sim/rsc_top_monitor.sv */
// assertion checker on the reset controller ports
`timescale 1ns/1ps
module rsc_top_monitor
#(
    parameter int HOLD_CYCLES = 16
)
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // causes
    input wire logic EXT_RESET_N_PIN,
    input wire logic WDT_TIMEOUT,
    input wire logic LOW_VOLTAGE,
    input wire logic BROWN_OUT,
    input wire logic CPU_RESET_REQ,
    input wire logic SYS_RESET_REQ,
    // outputs and bus
    input wire logic CHIP_RESET,
    input wire logic XTAL_RESET,
    input wire logic BOOT_SELECT,
    input wire logic IRQ,
    input wire logic AWVALID,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_cause;
        WDT_TIMEOUT | LOW_VOLTAGE | BROWN_OUT | CPU_RESET_REQ | SYS_RESET_REQ |=> CHIP_RESET[*2];
    endproperty
    a_cause: assert property (p_cause) else $error("no chip reset after cause");
    property p_pin;
        !EXT_RESET_N_PIN[*6] |=> CHIP_RESET;
    endproperty
    a_pin: assert property (p_pin) else $error("low pin without chip reset");
    property p_xtal_kept;
        !XTAL_RESET |=> !XTAL_RESET;
    endproperty
    a_xtal_kept: assert property (p_xtal_kept) else $error("crystal reset without power-on");
    property p_boot_kept;
        SYS_RESET_REQ && !AWVALID |=> $stable(BOOT_SELECT);
    endproperty
    a_boot_kept: assert property (p_boot_kept) else $error("boot select lost");
    property p_por;
        $fell(RST) |-> XTAL_RESET && CHIP_RESET && !BOOT_SELECT;
    endproperty
    a_por: assert property (p_por) else $error("power-on state wrong");
    property p_xtal_chip;
        XTAL_RESET |-> CHIP_RESET;
    endproperty
    a_xtal_chip: assert property (p_xtal_chip) else $error("crystal reset alone");
    property p_rd_answer;
        ARVALID && ARREADY |=> RVALID;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_one;
        RVALID |-> !ARREADY;
    endproperty
    a_rd_one: assert property (p_rd_one) else $error("second read accepted");
    property p_irq_quiet;
        CHIP_RESET |=> !IRQ;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt during chip reset");
endmodule : rsc_top_monitor
bind rsc_top rsc_top_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.CORE_CLK, .RST,
    .EXT_RESET_N_PIN, .WDT_TIMEOUT, .LOW_VOLTAGE, .BROWN_OUT, .CPU_RESET_REQ, .SYS_RESET_REQ,
    .CHIP_RESET, .XTAL_RESET, .BOOT_SELECT, .IRQ, .AWVALID, .ARVALID, .ARREADY, .RVALID);

/* sim/rsc_top_tb_top.sv */
// self-checking bench for the reset controller
`timescale 1ns/1ps
module rsc_top_tb_top;
    logic CORE_CLK = 1'h0;
    logic RST = 1'h1;
    logic press = 1'h0;
    logic [6:0] cz = 7'h00;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [3:0] WSTRB = 4'h0;
    logic [3:0] strb = 4'hF;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [1:0] BRESP, RRESP;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic EXT_RESET_N_PIN, CHIP_RESET, XTAL_RESET, BOOT_SELECT, IRQ;
    int failures = 0;
    int total_checks = 0;
    rsc_top #(.HOLD_CYCLES(2)) uut (.CORE_CLK, .RST, .EXT_RESET_N_PIN, .WDT_TIMEOUT(cz[2]),
        .LOW_VOLTAGE(cz[3]), .BROWN_OUT(cz[4]), .CPU_RESET_REQ(cz[5]), .SYS_RESET_REQ(cz[6]),
        .CHIP_RESET, .XTAL_RESET, .BOOT_SELECT, .IRQ, .AWADDR, .AWVALID, .AWREADY, .WDATA,
        .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
        .RDATA, .RRESP, .RVALID, .RREADY);
    rsc_pin_model pin (.clk(CORE_CLK), .press(press), .pin_n(EXT_RESET_N_PIN));
    always #5 CORE_CLK = ~CORE_CLK;
    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
            failures++;
        if (got !== exp)
            $display("ERROR %0t got %h exp %h", $time, got, exp);
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge CORE_CLK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= strb;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        forever
        begin
            @(posedge CORE_CLK);
            if (AWREADY)
                AWVALID <= 1'h0;
            if (WREADY)
                WVALID <= 1'h0;
            if (BVALID)
                break;
        end
        chk(32'(BRESP), 32'(e));
        BREADY <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge CORE_CLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        forever
        begin
            @(posedge CORE_CLK);
            if (ARREADY)
                ARVALID <= 1'h0;
            if (RVALID)
                break;
        end
        chk(RDATA, d);
        chk(32'(RRESP), 32'(e));
        RREADY <= 1'h0;
    endtask : rd
    task automatic settle;
        repeat (40)
        begin
            @(posedge CORE_CLK);
            if (CHIP_RESET === 1'h0)
                break;
        end
        chk(32'(CHIP_RESET), 32'h0);
    endtask : settle
    task automatic pulse(input int i);
        @(posedge CORE_CLK);
        cz <= 7'h01 << i;
        @(posedge CORE_CLK);
        cz <= 7'h00;
        #1;
        chk(32'(CHIP_RESET), 32'h1);
    endtask : pulse
    task automatic t_por;
        @(posedge CORE_CLK);
        #1;
        chk(32'({CHIP_RESET, XTAL_RESET, BOOT_SELECT}), 32'h6);
        settle();
        chk(32'(XTAL_RESET), 32'h0);
        rd(8'h04, 32'(rsc_pkg::CAUSE_FLAGS_RST), rsc_pkg::RESP_OKAY);
        rd(8'h14, 32'h0, rsc_pkg::RESP_OKAY);
    endtask : t_por
    task automatic t_sys;
        wr(8'h08, 32'h2, rsc_pkg::RESP_OKAY);
        pulse(rsc_pkg::CAUSE_SYS);
        chk(32'({XTAL_RESET, BOOT_SELECT}), 32'h1);
        settle();
        rd(8'h08, 32'h2, rsc_pkg::RESP_OKAY);
        strb = 4'hE;
        wr(8'h08, 32'h0, rsc_pkg::RESP_OKAY);
        rd(8'h08, 32'h2, rsc_pkg::RESP_OKAY);
        strb = 4'hF;
        rd(8'h04, 32'h41, rsc_pkg::RESP_OKAY);
        wr(8'h04, 32'h7F, rsc_pkg::RESP_OKAY);
        rd(8'h04, 32'h0, rsc_pkg::RESP_OKAY);
    endtask : t_sys
    task automatic t_causes;
        for (int i = rsc_pkg::CAUSE_WDT; i < rsc_pkg::CAUSE_COUNT; i++)
        begin
            pulse(i);
            settle();
            rd(8'h04, 32'h1 << i, rsc_pkg::RESP_OKAY);
            wr(8'h04, 32'h7F, rsc_pkg::RESP_OKAY);
        end
        press <= 1'h1;
        repeat (8) @(posedge CORE_CLK);
        #1;
        chk(32'(CHIP_RESET), 32'h1);
        press <= 1'h0;
        settle();
        rd(8'h04, 32'h2, rsc_pkg::RESP_OKAY);
    endtask : t_causes
    task automatic t_irq;
        wr(8'h10, 32'h7F, rsc_pkg::RESP_OKAY);
        wr(8'h14, 32'h4, rsc_pkg::RESP_OKAY);
        pulse(rsc_pkg::CAUSE_WDT);
        @(posedge CORE_CLK);
        #1;
        chk(32'(IRQ), 32'h0);
        settle();
        chk(32'(IRQ), 32'h0);
        rd(8'h0C, 32'h4, rsc_pkg::RESP_OKAY);
        wr(8'h14, 32'h1, rsc_pkg::RESP_OKAY);
        @(posedge CORE_CLK);
        chk(32'(IRQ), 32'h0);
        wr(8'h14, 32'h4, rsc_pkg::RESP_OKAY);
        @(posedge CORE_CLK);
        chk(32'(IRQ), 32'h1);
        wr(8'h10, 32'h4, rsc_pkg::RESP_OKAY);
        @(posedge CORE_CLK);
        chk(32'(IRQ), 32'h0);
        wr(8'h40, 32'h1, rsc_pkg::RESP_SLVERR);
        rd(8'h40, 32'h0, rsc_pkg::RESP_SLVERR);
        rd(8'h10, 32'h0, rsc_pkg::RESP_OKAY);
    endtask : t_irq
    task automatic t_rst2;
        @(posedge CORE_CLK);
        RST <= 1'h1;
        repeat (4) @(posedge CORE_CLK);
        RST <= 1'h0;
        t_por();
    endtask : t_rst2
    initial
    begin
        repeat (16) @(posedge CORE_CLK);
        RST <= 1'h0;
        t_por();
        t_sys();
        t_causes();
        t_irq();
        t_rst2();
        test_done();
    end
    initial
    begin
        #100000;
        failures++;
        test_done();
    end
endmodule : rsc_top_tb_top

/* verilog/rsc_pin_sync.sv */
// three flip-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module rsc_pin_sync
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin and filtered level
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // level moves only when second and third stages agree
    always_ff @(posedge clk)
    begin
        if (rst)
            level <= 1'b1;
        else if (s2 == s3)
            level <= s3;
    end
endmodule : rsc_pin_sync

/* verilog/rsc_pkg.sv */
// constants for the chip reset source controller
package rsc_pkg;
    // byte addresses of the register words
    localparam logic [7:0] ADDR_CAUSE_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_FLASH_PROG_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_INT_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;
    // cause flag positions
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_WDT = 2;
    localparam int CAUSE_LVR = 3;
    localparam int CAUSE_BOD = 4;
    localparam int CAUSE_CPU = 5;
    localparam int CAUSE_SYS = 6;
    localparam int CAUSE_COUNT = 7;
    // boot select position in the flash programming control word
    localparam int BOOT_SELECT_POS = 1;
    // values after power-on reset
    localparam logic [6:0] CAUSE_FLAGS_RST = 7'h01;
    localparam logic [6:0] INT_STATUS_RST = 7'h01;
    localparam logic [6:0] INT_ENABLE_RST = 7'h00;
    localparam logic BOOT_SELECT_RST = 1'b0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing: chip reset pulse length
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_HOLD_NS = 160;
    localparam int RST_HOLD_CYCLES = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : rsc_pkg

/* verilog/rsc_top.sv */
// chip reset source controller with axi4-lite register slave
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - any of seven causes starts a whole-chip reset pulse
// - each cause sets its own flag, readable in the cause flag register
// - external reset pin is active low; low level resets the chip
// - system and power-on reset both reset the whole chip and peripherals
// - system reset keeps crystal circuit and boot select bit unchanged
// - power-on reset also resets crystal circuit and boot select bit
// - cause flag register at offset 0x04, read/write, low byte by cause
module rsc_top
#(
    parameter int HOLD_CYCLES = rsc_pkg::RST_HOLD_CYCLES
)
(
    // clock and power-on reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // reset causes
    input wire logic EXT_RESET_N_PIN,
    input wire logic WDT_TIMEOUT,
    input wire logic LOW_VOLTAGE,
    input wire logic BROWN_OUT,
    input wire logic CPU_RESET_REQ,
    input wire logic SYS_RESET_REQ,
    // reset outputs and interrupt
    output logic CHIP_RESET,
    output logic XTAL_RESET,
    output logic BOOT_SELECT,
    output logic IRQ,
    // axi4-lite write address
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // axi4-lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // axi4-lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read address
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // axi4-lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 1)
    begin : g_check
        $error("HOLD_CYCLES must be at least one");
    end

    logic pin_level;
    logic [6:0] cause_hit;
    logic [6:0] cause_flags;
    logic [6:0] int_status;
    logic [6:0] int_enable;
    logic [CW-1:0] hold_cnt;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic wr_fire;
    logic [6:0] flag_clr;
    logic [6:0] stat_clr;

    // pin from the board crosses into the core clock
    rsc_pin_sync u_pin_sync
    (
        .clk(CORE_CLK),
        .rst(RST),
        .pin(EXT_RESET_N_PIN),
        .level(pin_level)
    );

    // decode of a register address into a known word
    function automatic logic mapped(input logic [7:0] a);
        if (a == rsc_pkg::ADDR_CAUSE_FLAGS)
            mapped = 1'b1;
        else if (a == rsc_pkg::ADDR_FLASH_PROG_CONTROL)
            mapped = 1'b1;
        else if (a == rsc_pkg::ADDR_INT_STATUS)
            mapped = 1'b1;
        else if (a == rsc_pkg::ADDR_INT_CLEAR)
            mapped = 1'b1;
        else if (a == rsc_pkg::ADDR_INT_ENABLE)
            mapped = 1'b1;
        else
            mapped = 1'b0;
    endfunction : mapped

    // cause vector; power-on is taken by RST itself
    always_comb
    begin
        cause_hit = '0;
        cause_hit[rsc_pkg::CAUSE_PIN] = ~pin_level;
        cause_hit[rsc_pkg::CAUSE_WDT] = WDT_TIMEOUT;
        cause_hit[rsc_pkg::CAUSE_LVR] = LOW_VOLTAGE;
        cause_hit[rsc_pkg::CAUSE_BOD] = BROWN_OUT;
        cause_hit[rsc_pkg::CAUSE_CPU] = CPU_RESET_REQ;
        cause_hit[rsc_pkg::CAUSE_SYS] = SYS_RESET_REQ;
    end

    // chip reset pulse, reloaded while any cause stays active
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            hold_cnt <= CW'(HOLD_CYCLES);
            CHIP_RESET <= 1'b1;
        end
        else if (|cause_hit)
        begin
            hold_cnt <= CW'(HOLD_CYCLES);
            CHIP_RESET <= 1'b1;
        end
        else if (hold_cnt != '0)
        begin
            hold_cnt <= hold_cnt - CW'(1);
            CHIP_RESET <= (hold_cnt != CW'(1));
        end
        else
            CHIP_RESET <= 1'b0;
    end

    // crystal reset only follows power-on
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            XTAL_RESET <= 1'b1;
        else if (hold_cnt <= CW'(1))
            XTAL_RESET <= 1'b0;
    end

    // write channel holding
    assign wr_fire = aw_held && w_held && !BVALID;

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            aw_held <= 1'b0;
            AWREADY <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (AWVALID && AWREADY)
        begin
            aw_held <= 1'b1;
            AWREADY <= 1'b0;
            aw_addr <= AWADDR;
        end
        else if (wr_fire)
            aw_held <= 1'b0;
        else
            AWREADY <= !aw_held && !BVALID;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            w_held <= 1'b0;
            WREADY <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (WVALID && WREADY)
        begin
            w_held <= 1'b1;
            WREADY <= 1'b0;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end
        else if (wr_fire)
            w_held <= 1'b0;
        else
            WREADY <= !w_held && !BVALID;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            BVALID <= 1'b0;
            BRESP <= rsc_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            BVALID <= 1'b1;
            BRESP <= mapped(aw_addr) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
        end
        else if (BREADY)
            BVALID <= 1'b0;
    end

    // write-one-to-clear strobes, low byte lane only
    always_comb
    begin
        flag_clr = '0;
        stat_clr = '0;
        if (wr_fire && w_strb[0])
        begin
            if (aw_addr == rsc_pkg::ADDR_CAUSE_FLAGS)
                flag_clr = w_data[6:0];
            else if (aw_addr == rsc_pkg::ADDR_INT_CLEAR)
                stat_clr = w_data[6:0];
        end
    end

    // cause flags: set wins over clear, untouched by the chip reset
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            cause_flags <= rsc_pkg::CAUSE_FLAGS_RST;
        else
            cause_flags <= (cause_flags & ~flag_clr) | cause_hit;
    end

    // interrupt status, sticky
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            int_status <= rsc_pkg::INT_STATUS_RST;
        else
            int_status <= (int_status & ~stat_clr) | cause_hit;
    end

    // interrupt enable, cleared by every chip reset
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || CHIP_RESET || (|cause_hit))
            int_enable <= rsc_pkg::INT_ENABLE_RST;
        else if (wr_fire && w_strb[0] && aw_addr == rsc_pkg::ADDR_INT_ENABLE)
            int_enable <= w_data[6:0];
    end

    // boot select survives system reset, cleared at power-on, loaded from bit 1 by a flash programming control write
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            BOOT_SELECT <= rsc_pkg::BOOT_SELECT_RST;
        else if (wr_fire && w_strb[0] && aw_addr == rsc_pkg::ADDR_FLASH_PROG_CONTROL)
            BOOT_SELECT <= w_data[rsc_pkg::BOOT_SELECT_POS];
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            IRQ <= 1'b0;
        else
            IRQ <= |(int_status & int_enable);
    end

    // read channel
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= rsc_pkg::RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RRESP <= mapped(ARADDR) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
            if (ARADDR == rsc_pkg::ADDR_CAUSE_FLAGS)
                RDATA <= {25'h0, cause_flags};
            else if (ARADDR == rsc_pkg::ADDR_FLASH_PROG_CONTROL)
                RDATA <= {30'h0, BOOT_SELECT, 1'b0};
            else if (ARADDR == rsc_pkg::ADDR_INT_STATUS)
                RDATA <= {25'h0, int_status};
            else if (ARADDR == rsc_pkg::ADDR_INT_ENABLE)
                RDATA <= {25'h0, int_enable};
            else
                RDATA <= 32'h0000_0000;
        end
        else if (RVALID)
        begin
            if (RREADY)
                RVALID <= 1'b0;
        end
        else
            ARREADY <= 1'b1;
    end
endmodule : rsc_top
